// ===== common/sfcf_defs.svh
`ifndef SFCF_DEFS_SVH
`define SFCF_DEFS_SVH
// How it works
// - A command byte that is not recognised sends the block to standby, deaf to the bus until the next select fall.
// - In standby the serial output lanes are never driven.
// - A recognised command makes the block active until the select line next rises.
// - Input bits are taken on the rising serial clock edge and output bits are launched on the falling edge.
// - Clock idle low and clock idle high both work, with the same capture and launch edges.
// - A read-class command may be ended by raising select after any output bit and the output stops cleanly.
// - A write-class command is executed only if select rises on a byte boundary, otherwise it is rejected.
// - Array access commands are ignored while a write, program or erase runs, leaving it undisturbed.
// - In four-line mode the command, address and data output phases all use four lanes.
// - Opcode 35h switches the block into the four-line command protocol.
// - Entering four-line mode selects 4-4-4 transfers and leaves the stored quad enable bit untouched.
// - Opcode F5h or a system reset leaves the four-line command protocol.
// - After opcode F5h command bytes arrive on a single lane again.

// read class
`define SFCF_OP_READ        8'h03
`define SFCF_OP_FAST_READ   8'h0B
`define SFCF_OP_READ_STATUS 8'h05
`define SFCF_OP_READ_ID     8'h9F
`define SFCF_OP_QUAD_ID     8'hAF
// write class
`define SFCF_OP_WR_EN       8'h06
`define SFCF_OP_WR_DIS      8'h04
`define SFCF_OP_STATUS_WR   8'h01
`define SFCF_OP_PROGRAM     8'h02
`define SFCF_OP_SECT_ERASE  8'h20
`define SFCF_OP_BLK32_ERASE 8'h52
`define SFCF_OP_BLK_ERASE   8'hD8
`define SFCF_OP_CHIP_ERASE  8'h60
`define SFCF_OP_CHIP_ERASE2 8'hC7
`define SFCF_OP_POWER_DOWN  8'hB9
`define SFCF_OP_NOP         8'h00
`define SFCF_OP_QPI_ENTER   8'h35
`define SFCF_OP_QPI_EXIT    8'hF5
// argument byte counts
`define SFCF_ARGS_NONE      3'h0
`define SFCF_ARGS_ADDR      3'h3
`define SFCF_ARGS_ADDR_DUMMY 3'h4
// lanes and widths
`define SFCF_STEP_SINGLE    4'h1
`define SFCF_STEP_QUAD      4'h4
`define SFCF_OE_OFF         4'h0
`define SFCF_OE_SINGLE      4'h2
`define SFCF_OE_QUAD        4'hF
`define SFCF_FILL_BYTE      8'hFF
`define SFCF_PIN_RST        6'h10
`define SFCF_FIFO_WIDTH     8
`define SFCF_FIFO_DEPTH     16
`endif

// ===== common/sfcf_pkg.sv
package sfcf_pkg;
    // command classes after decode
    typedef enum logic [1:0] {
        CLS_BAD,
        CLS_READ,
        CLS_WRITE
    } sfcf_cls_t;

    // frame states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_ARG,
        ST_OUT,
        ST_WDATA,
        ST_STANDBY
    } sfcf_state_t;

    typedef struct packed {
        sfcf_cls_t  cls;
        logic       array;
        logic [2:0] args;
    } sfcf_dec_t;
endpackage

// ===== core/sfcf_fifo.sv
`timescale 1ns/10ps
module sfcf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             clear,
    // fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // drain side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic [AW:0]      count_d;
    logic             push;
    logic             pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_valid = (count_q != '0);
    assign out_data  = mem_q[rd_ptr_q];

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + (AW+1)'(1);
        end else if (pop && !push) begin
            count_d = count_q - (AW+1)'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || clear) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
            in_ready <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + AW'(1);
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + AW'(1);
            end
            count_q  <= count_d;
            // ready is registered so the fill side sees a clean flop
            in_ready <= (count_d != (AW+1)'(DEPTH));
        end
    end
endmodule // sfcf_fifo

// ===== core/sfcf_frontend.sv
`timescale 1ns/10ps
`include "sfcf_defs.svh"
module sfcf_frontend
    import sfcf_pkg::*;
#(
    parameter int FIFO_WIDTH = `SFCF_FIFO_WIDTH,
    parameter int FIFO_DEPTH = `SFCF_FIFO_DEPTH
) (
    // system
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // flash pins
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic [3:0] io_in,
    output logic      [3:0] io_out,
    output logic      [3:0] io_oe,
    // read data from the core
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid,
    output logic            rd_ready,
    // core status
    input  wire logic       busy,
    // command results
    output logic      [7:0] cmd_opcode,
    output logic            cmd_read_start,
    output logic            cmd_exec,
    output logic            cmd_reject,
    output logic      [7:0] rx_data,
    output logic            rx_valid,
    output logic            active,
    output logic            qpi_mode
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [5:0] pin_s1_q;
    logic [5:0] pin_s2_q;
    logic [5:0] pin_s3_q;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pin_s1_q <= `SFCF_PIN_RST;
            pin_s2_q <= `SFCF_PIN_RST;
            pin_s3_q <= `SFCF_PIN_RST;
        end else begin
            pin_s1_q <= {sclk, cs_n, io_in};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_fall;
    logic       cs_rise;
    logic [3:0] io_s;

    // edges found from the sampled clock level, so idle low or idle high
    // makes no difference to which edge captures and which launches
    assign sclk_rise = pin_s2_q[5] && !pin_s3_q[5];
    assign sclk_fall = !pin_s2_q[5] && pin_s3_q[5];
    assign cs_fall   = !pin_s2_q[4] && pin_s3_q[4];
    assign cs_rise   = pin_s2_q[4] && !pin_s3_q[4];
    // data is delayed by the same two stages as the clock, so it stays aligned
    assign io_s      = pin_s2_q[3:0];

    // ****************************************
    // command decode
    // ****************************************
    function automatic sfcf_dec_t decode(input logic [7:0] op, input logic quad, input logic dev_busy);
        sfcf_dec_t d;
        d.cls   = CLS_BAD;
        d.array = 1'b0;
        d.args  = `SFCF_ARGS_NONE;
        case (op)
            `SFCF_OP_READ: begin
                d.cls   = quad ? CLS_BAD : CLS_READ;
                d.array = 1'b1;
                d.args  = `SFCF_ARGS_ADDR;
            end
            `SFCF_OP_FAST_READ: begin
                d.cls   = quad ? CLS_BAD : CLS_READ;
                d.array = 1'b1;
                d.args  = `SFCF_ARGS_ADDR_DUMMY;
            end
            `SFCF_OP_READ_STATUS: begin
                d.cls = CLS_READ;
            end
            `SFCF_OP_READ_ID: begin
                d.cls = quad ? CLS_BAD : CLS_READ;
            end
            `SFCF_OP_QUAD_ID: begin
                d.cls = quad ? CLS_READ : CLS_BAD;
            end
            `SFCF_OP_PROGRAM, `SFCF_OP_SECT_ERASE, `SFCF_OP_BLK32_ERASE,
            `SFCF_OP_BLK_ERASE, `SFCF_OP_CHIP_ERASE, `SFCF_OP_CHIP_ERASE2: begin
                d.cls   = CLS_WRITE;
                d.array = 1'b1;
            end
            `SFCF_OP_WR_EN, `SFCF_OP_WR_DIS, `SFCF_OP_STATUS_WR,
            `SFCF_OP_POWER_DOWN, `SFCF_OP_NOP: begin
                d.cls = CLS_WRITE;
            end
            `SFCF_OP_QPI_ENTER: begin
                d.cls = quad ? CLS_BAD : CLS_WRITE;
            end
            `SFCF_OP_QPI_EXIT: begin
                d.cls = quad ? CLS_WRITE : CLS_BAD;
            end
            default: begin
                d.cls = CLS_BAD;
            end
        endcase
        // array access during a running write is dropped, core never sees it
        if (d.array && dev_busy) begin
            d.cls = CLS_BAD;
        end
        return d;
    endfunction

    // ****************************************
    // input shifter
    // ****************************************
    sfcf_state_t state_q;
    logic [7:0]  in_sh_q;
    logic [2:0]  bit_cnt_q;
    logic [2:0]  arg_left_q;
    logic [3:0]  step;
    logic [3:0]  bit_sum;
    logic [7:0]  shift_in;
    logic        receiving;
    logic        byte_in_done;
    sfcf_dec_t   dec;

    assign step      = qpi_mode ? `SFCF_STEP_QUAD : `SFCF_STEP_SINGLE;
    assign bit_sum   = {1'b0, bit_cnt_q} + step;
    // four lanes take a nibble per clock, upper nibble first, lane 3 on top
    assign shift_in  = qpi_mode ? {in_sh_q[3:0], io_s} : {in_sh_q[6:0], io_s[0]};
    assign receiving = (state_q == ST_CMD) || (state_q == ST_ARG) || (state_q == ST_WDATA);
    assign byte_in_done = sclk_rise && receiving && bit_sum[3];
    assign dec       = decode(shift_in, qpi_mode, busy);

    always_ff @(posedge sys_clk) begin
        if (sys_rst || cs_fall) begin
            in_sh_q   <= 8'h00;
            bit_cnt_q <= 3'h0;
        end else if (sclk_rise && receiving) begin
            in_sh_q   <= shift_in;
            bit_cnt_q <= bit_sum[2:0];
        end
    end

    // ****************************************
    // frame state
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
        end else if (cs_rise) begin
            state_q <= ST_IDLE;
        end else if (cs_fall) begin
            state_q <= ST_CMD;
        end else if (byte_in_done) begin
            unique case (state_q)
                ST_CMD: begin
                    unique case (dec.cls)
                        CLS_BAD: begin
                            state_q <= ST_STANDBY;
                        end
                        CLS_READ: begin
                            state_q <= (dec.args == `SFCF_ARGS_NONE) ? ST_OUT : ST_ARG;
                        end
                        CLS_WRITE: begin
                            state_q <= ST_WDATA;
                        end
                        default: begin
                            state_q <= ST_STANDBY;
                        end
                    endcase
                end
                ST_ARG: begin
                    if (arg_left_q == 3'h1) begin
                        state_q <= ST_OUT;
                    end
                end
                ST_WDATA: begin
                    state_q <= ST_WDATA;
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            arg_left_q <= 3'h0;
        end else if (byte_in_done && state_q == ST_CMD) begin
            arg_left_q <= dec.args;
        end else if (byte_in_done && state_q == ST_ARG) begin
            arg_left_q <= arg_left_q - 3'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            active <= 1'b0;
        end else begin
            active <= (state_q == ST_ARG) || (state_q == ST_OUT) || (state_q == ST_WDATA);
        end
    end

    // ****************************************
    // read data buffer
    // ****************************************
    logic [7:0] fifo_data;
    logic       fifo_valid;
    logic       fifo_pop;
    logic [3:0] out_left_q;
    logic [7:0] out_sh_q;
    logic [7:0] next_byte;

    // pop as each new byte starts to launch
    assign fifo_pop  = (state_q == ST_OUT) && sclk_fall && (out_left_q == 4'h0);
    // an empty buffer gives fill bytes rather than stalling the host clock
    assign next_byte = fifo_valid ? fifo_data : `SFCF_FILL_BYTE;

    sfcf_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .clear     (cs_rise),
        .in_data   (rd_data),
        .in_valid  (rd_valid),
        .in_ready  (rd_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // ****************************************
    // output launcher
    // ****************************************
    function automatic logic [3:0] lanes(input logic [7:0] b, input logic quad);
        return quad ? b[7:4] : {2'b00, b[7], 1'b0};
    endfunction

    always_ff @(posedge sys_clk) begin
        if (sys_rst || state_q != ST_OUT) begin
            // select high, standby and input phases all release the lanes
            io_oe      <= `SFCF_OE_OFF;
            io_out     <= 4'h0;
            out_sh_q   <= 8'h00;
            out_left_q <= 4'h0;
        end else if (cs_rise) begin
            io_oe      <= `SFCF_OE_OFF;
            out_left_q <= 4'h0;
        end else if (sclk_fall) begin
            io_oe <= qpi_mode ? `SFCF_OE_QUAD : `SFCF_OE_SINGLE;
            if (out_left_q == 4'h0) begin
                io_out     <= lanes(next_byte, qpi_mode);
                out_sh_q   <= qpi_mode ? {next_byte[3:0], 4'h0} : {next_byte[6:0], 1'b0};
                out_left_q <= 4'h8 - step;
            end else begin
                io_out     <= lanes(out_sh_q, qpi_mode);
                out_sh_q   <= qpi_mode ? {out_sh_q[3:0], 4'h0} : {out_sh_q[6:0], 1'b0};
                out_left_q <= out_left_q - step;
            end
        end
    end

    // ****************************************
    // command reporting
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cmd_opcode     <= 8'h00;
            cmd_read_start <= 1'b0;
        end else begin
            cmd_read_start <= 1'b0;
            if (byte_in_done && state_q == ST_CMD && dec.cls != CLS_BAD) begin
                cmd_opcode     <= shift_in;
                cmd_read_start <= (dec.cls == CLS_READ);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rx_data  <= 8'h00;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= byte_in_done && (state_q == ST_ARG || state_q == ST_WDATA);
            if (byte_in_done && (state_q == ST_ARG || state_q == ST_WDATA)) begin
                rx_data <= shift_in;
            end
        end
    end

    logic on_boundary;
    assign on_boundary = (bit_cnt_q == 3'h0);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cmd_exec   <= 1'b0;
            cmd_reject <= 1'b0;
        end else begin
            cmd_exec   <= cs_rise && (state_q == ST_WDATA) && on_boundary;
            cmd_reject <= cs_rise && (state_q == ST_WDATA) && !on_boundary;
        end
    end

    // ****************************************
    // protocol mode
    // ****************************************
    // only the lane count changes here; the stored quad enable bit lives in
    // the core and is never written by a mode switch
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            qpi_mode <= 1'b0;
        end else if (cs_rise && state_q == ST_WDATA && on_boundary) begin
            if (cmd_opcode == `SFCF_OP_QPI_ENTER && !qpi_mode) begin
                qpi_mode <= 1'b1;
            end else if (cmd_opcode == `SFCF_OP_QPI_EXIT && qpi_mode) begin
                qpi_mode <= 1'b0;
            end
        end
    end

endmodule // sfcf_frontend

// ===== testbench/sfcf_frontend_properties.sv
`timescale 1ns/10ps
// ****
// front end port checks
// ****
module sfcf_frontend_properties
    import sfcf_pkg::*;
#(
    parameter int FIFO_WIDTH = 8,
    parameter int FIFO_DEPTH = 16
) (
    // system
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    // pins
    input wire logic       sclk,
    input wire logic       cs_n,
    input wire logic [3:0] io_in,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe,
    // core side
    input wire logic [7:0] rd_data,
    input wire logic       rd_valid,
    input wire logic       rd_ready,
    input wire logic       busy,
    input wire logic [7:0] cmd_opcode,
    input wire logic       cmd_read_start,
    input wire logic       cmd_exec,
    input wire logic       cmd_reject,
    input wire logic [7:0] rx_data,
    input wire logic       rx_valid,
    input wire logic       active,
    input wire logic       qpi_mode
);
    // select is synchronised, so allow some lag
    logic [3:0] cs_hi_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !cs_n) begin
            cs_hi_q <= 4'h0;
        end else if (cs_hi_q != 4'hF) begin
            cs_hi_q <= cs_hi_q + 4'h1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    property p_idle_quiet;
        cs_hi_q >= 4'h6 |-> io_oe == 4'h0 && !active && !rx_valid;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("drive while deselected");
    property p_oe_lanes;
        io_oe != 4'h0 |-> io_oe == (qpi_mode ? 4'hF : 4'h2);
    endproperty
    a_oe_lanes: assert property (p_oe_lanes) else $error("wrong output lanes");
    property p_launch_fall;
        io_oe != 4'h0 && !$stable(io_out) |-> !$past(sclk, 2);
    endproperty
    a_launch_fall: assert property (p_launch_fall) else $error("output not after fall");
    property p_exec_cs;
        cmd_exec || cmd_reject |-> cs_n && $past(cs_n, 2);
    endproperty
    a_exec_cs: assert property (p_exec_cs) else $error("verdict before select rise");
    property p_exec_pulse;
        cmd_exec |-> !cmd_reject ##1 !cmd_exec;
    endproperty
    a_exec_pulse: assert property (p_exec_pulse) else $error("verdict pulse wrong");
    property p_read_start;
        cmd_read_start |-> !cs_n && cmd_opcode inside {8'h03, 8'h0B, 8'h05, 8'h9F, 8'hAF} ##1 !cmd_read_start;
    endproperty
    a_read_start: assert property (p_read_start) else $error("bad read start");
    property p_busy_block;
        (cmd_exec || cmd_read_start) && busy |-> !(cmd_opcode inside {8'h03, 8'h0B, 8'h02, 8'h20,
                                                                       8'h52, 8'hD8, 8'h60, 8'hC7});
    endproperty
    a_busy_block: assert property (p_busy_block) else $error("array access while busy");
    property p_qpi_switch;
        !$stable(qpi_mode) |-> cmd_exec && cmd_opcode == (qpi_mode ? 8'h35 : 8'hF5);
    endproperty
    a_qpi_switch: assert property (p_qpi_switch) else $error("mode change without command");
endmodule // sfcf_frontend_properties

bind sfcf_frontend sfcf_frontend_properties #(.FIFO_WIDTH(FIFO_WIDTH), .FIFO_DEPTH(FIFO_DEPTH)) u_props (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .busy(busy),
    .cmd_opcode(cmd_opcode), .cmd_read_start(cmd_read_start), .cmd_exec(cmd_exec),
    .cmd_reject(cmd_reject), .rx_data(rx_data), .rx_valid(rx_valid), .active(active), .qpi_mode(qpi_mode)
);

// ===== testbench/sfcf_host_model.sv
`timescale 1ns/10ps
// ****
// host controller model
// ****
module sfcf_host_model (
    // phase reference
    input  wire logic       sys_clk,
    // flash pins
    input  wire logic [3:0] io_wire,
    output logic            sclk,
    output logic            cs_n,
    output logic      [3:0] io_drv
);
    logic idle_lvl;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        io_drv = 4'hA;
        idle_lvl = 1'b0;
    end
    // fixed offset keeps pin edges clear of the system clock edge
    task automatic align();
        @(posedge sys_clk);
        #37;
    endtask
    task automatic begin_frame(input logic mode3);
        align();
        idle_lvl = mode3;
        sclk = mode3;
        #400;
        cs_n = 1'b0;
        #400;
    endtask
    task automatic end_frame();
        align();
        sclk = idle_lvl;
        io_drv = ~io_drv;
        #400;
        cs_n = 1'b1;
        #1200;
    endtask
    // undriven lanes toggle so a stale level never looks valid
    task automatic put(input logic [7:0] b, input logic quad, input int clocks);
        int i;
        align();
        for (i = 0; i < clocks; i++) begin
            sclk = 1'b0;
            io_drv = quad ? (i[0] ? b[3:0] : b[7:4]) : {~io_drv[3:1], b[7-i]};
            #400;
            sclk = 1'b1;
            #400;
        end
    endtask
    task automatic get(output logic [7:0] b, input logic quad, input int clocks);
        int i;
        b = 8'h00;
        align();
        for (i = 0; i < clocks; i++) begin
            sclk = 1'b0;
            io_drv = ~io_drv;
            #400;
            sclk = 1'b1;
            b = quad ? {b[3:0], io_wire} : {b[6:0], io_wire[1]};
            #400;
        end
    endtask
endmodule // sfcf_host_model

// ===== testbench/tb_sfcf_frontend.sv
`timescale 1ns/10ps
// ****
// front end bench
// ****
module tb_sfcf_frontend;
    localparam int EXE = 0, REJ = 1, RDS = 2, ARG = 3, DRV = 4;
    logic       sys_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       busy = 1'b0;
    logic       rd_valid = 1'b0;
    logic [7:0] rd_data = 8'h00;
    logic [3:0] io_drv, io_out, io_oe;
    logic       sclk, cs_n, rd_ready, cmd_read_start, cmd_exec, cmd_reject, rx_valid, active, qpi_mode;
    logic [7:0] cmd_opcode, rx_data;
    wire  [3:0] io_wire = (io_oe & io_out) | (~io_oe & io_drv);
    int         err_count = 0, samples_checked = 0, seed = 32'h12e307ce, n_push;
    int         cnt[5];
    logic [7:0] exp_q[$];
    logic [7:0] wops[9] = '{8'h06, 8'h04, 8'h60, 8'hC7, 8'hB9, 8'h00, 8'h01, 8'h20, 8'h02};
    int         wargs[9] = '{0, 0, 0, 0, 0, 0, 1, 3, 4};

    sfcf_frontend #(.FIFO_WIDTH(8), .FIFO_DEPTH(16)) DUT (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .io_in(io_wire),
        .io_out(io_out), .io_oe(io_oe), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .busy(busy), .cmd_opcode(cmd_opcode), .cmd_read_start(cmd_read_start), .cmd_exec(cmd_exec),
        .cmd_reject(cmd_reject), .rx_data(rx_data), .rx_valid(rx_valid), .active(active), .qpi_mode(qpi_mode)
    );
    sfcf_host_model host (.sys_clk(sys_clk), .io_wire(io_wire), .sclk(sclk), .cs_n(cs_n), .io_drv(io_drv));

    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cnt[EXE] += int'(cmd_exec === 1'b1);
        cnt[REJ] += int'(cmd_reject === 1'b1);
        cnt[RDS] += int'(cmd_read_start === 1'b1);
        cnt[ARG] += int'(rx_valid === 1'b1);
        cnt[DRV] += int'(io_oe !== 4'h0);
    end

    task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_cnt(input string what, input int exp, input int got);
        samples_checked++;
        if (got != exp) begin
            err_count++;
            $display("unexpected %s: expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic chk_frame(input int e_exec, input int e_rej, input int e_arg);
        chk_cnt("exec pulses", e_exec, cnt[EXE]);
        chk_cnt("reject pulses", e_rej, cnt[REJ]);
        chk_cnt("argument bytes", e_arg, cnt[ARG]);
    endtask
    task automatic do_reset();
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
    endtask
    // sclk stays high here, so nothing pops
    task automatic push(input int n);
        int k;
        @(posedge sys_clk);
        for (k = 0; k < n; k++) begin
            rd_data <= 8'($random(seed));
            rd_valid <= 1'b1;
            @(posedge sys_clk);
            if (rd_ready !== 1'b1) break;
            exp_q.push_back(rd_data);
        end
        rd_valid <= 1'b0;
    endtask
    task automatic frame(input logic [7:0] op, input logic quad, input int nargs, input int extra);
        int k;
        logic [7:0] a;
        cnt = '{default: 0};
        host.begin_frame(1'($random(seed)));
        host.put(op, quad, quad ? 2 : 8);
        for (k = 0; k < nargs; k++) begin
            a = 8'($random(seed));
            host.put(a, quad, quad ? 2 : 8);
        end
        if (extra > 0) host.put(8'($random(seed)), quad, extra);
        host.end_frame();
        if (cnt[ARG] > 0) chk_val("last arg", a, rx_data);
    endtask
    task automatic rd_frame(input logic [7:0] op, input logic quad, input logic mode3, input int npush,
                            input int nget, input int cut);
        logic [7:0] b;
        int         k;
        cnt = '{default: 0};
        exp_q.delete();
        host.begin_frame(mode3);
        host.put(op, quad, quad ? 2 : 8);
        push(npush);
        n_push = exp_q.size();
        for (k = 0; k < nget; k++) begin
            host.get(b, quad, quad ? 2 : 8);
            chk_val("read byte", exp_q.size() > 0 ? exp_q.pop_front() : 8'hFF, b);
        end
        if (cut > 0) host.get(b, quad, cut);
        host.end_frame();
        chk_cnt("read start", 1, cnt[RDS]);
    endtask
    task automatic test_end(input string name);
        $display("test %s finished", name);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #2_000_000;
        err_count++;
        $display("watchdog expired");
        stop_test();
    end
    initial begin
        int k;
        do_reset();
        for (k = 0; k < 2; k++) begin
            rd_frame(8'h05, 1'b0, k[0], 1, 1, 0);
            chk_val("opcode", 8'h05, cmd_opcode);
        end
        rd_frame(8'h9F, 1'b0, 1'b0, 3, 3, 0);
        rd_frame(8'h05, 1'b0, 1'b1, 1, 0, 3);
        chk_frame(0, 0, 0);
        chk_val("oe after cut", 8'h00, {4'h0, io_oe});
        test_end("reads");
        for (k = 0; k < 9; k++) begin
            frame(wops[k], 1'b0, wargs[k], 0);
            chk_frame(1, 0, wargs[k]);
        end
        for (k = 1; k < 8; k += 6) begin
            frame(8'h06, 1'b0, 0, k);
            chk_frame(0, 1, 0);
        end
        test_end("writes");
        @(posedge sys_clk);
        busy <= 1'b1;
        frame(8'h20, 1'b0, 3, 0);
        chk_frame(0, 0, 0);
        frame(8'h03, 1'b0, 4, 0);
        chk_cnt("read drive", 0, cnt[DRV] + cnt[RDS] + cnt[ARG]);
        frame(8'h01, 1'b0, 1, 0);
        chk_frame(1, 0, 1);
        @(posedge sys_clk);
        busy <= 1'b0;
        frame(8'h77, 1'b0, 1, 0);
        chk_frame(0, 0, 0);
        chk_cnt("drive cycles", 0, cnt[DRV]);
        frame(8'h06, 1'b0, 0, 0);
        chk_frame(1, 0, 0);
        test_end("busy and invalid");
        frame(8'h35, 1'b0, 0, 0);
        chk_val("quad mode", 8'h01, {7'h0, qpi_mode});
        rd_frame(8'hAF, 1'b1, 1'b0, 1, 2, 0);
        frame(8'h35, 1'b1, 0, 0);
        chk_frame(0, 0, 0);
        frame(8'h06, 1'b1, 0, 1);
        chk_frame(0, 1, 0);
        frame(8'hF5, 1'b1, 0, 0);
        chk_val("quad mode", 8'h00, {7'h0, qpi_mode});
        rd_frame(8'h05, 1'b0, 1'b0, 1, 1, 0);
        test_end("quad");
        rd_frame(8'h05, 1'b0, 1'b0, 20, 17, 0);
        chk_cnt("fifo fill", 16, n_push);
        test_end("fifo");
        frame(8'h35, 1'b0, 0, 0);
        do_reset();
        chk_val("quad after reset", 8'h00, {7'h0, qpi_mode});
        rd_frame(8'h05, 1'b0, 1'b1, 1, 1, 0);
        test_end("reset");
        stop_test();
    end
endmodule // tb_sfcf_frontend
